// file: common/axd_pkg.sv
// constants and types shared by the auxiliary converter control logic
package axd_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [4:0] AXD_ADDR_I_CODE = 5'h09;
    localparam logic [4:0] AXD_ADDR_I_CTRL = 5'h0a;
    localparam logic [4:0] AXD_ADDR_Q_CODE = 5'h0b;
    localparam logic [4:0] AXD_ADDR_Q_CTRL = 5'h0c;

    // control register fields
    localparam int AXD_CTRL_EN_BIT     = 7;
    localparam int AXD_CTRL_RANGE_HI   = 6;
    localparam int AXD_CTRL_RANGE_LO   = 5;
    localparam int AXD_CTRL_OFS_HI     = 4;
    localparam int AXD_CTRL_OFS_LO     = 2;
    localparam int AXD_CTRL_CODE_HI    = 1;
    localparam int AXD_CTRL_CODE_LO    = 0;

    localparam logic [7:0] AXD_CODE_RESET = 8'h00;
    localparam logic [7:0] AXD_CTRL_RESET = 8'h00;

    localparam int         AXD_CODE_W     = 10;
    localparam int         AXD_OFS_W      = 3;
    localparam int         AXD_RANGE_W    = 2;
    localparam logic [2:0] AXD_OFS_BYPASS = 3'h7;
    // shunt select index: 0 is 16 kohm, larger is lower; 4 is the 3.2 kohm floor
    localparam logic [2:0] AXD_SHUNT_FLOOR = 3'h4;

    // ------------------------------------------------------------------
    // serial frame
    // ------------------------------------------------------------------
    localparam int         AXD_FRAME_BITS = 16;
    localparam int         AXD_INSTR_BITS = 8;
    localparam int         AXD_READ_BIT   = 7;
    localparam logic [7:0] AXD_UNMAPPED   = 8'h00;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int AXD_CLK_PERIOD_NS   = 10;
    localparam int AXD_MODE_PULSE_NS   = 50;
    localparam int AXD_MODE_PULSE_CYC  = (AXD_MODE_PULSE_NS + AXD_CLK_PERIOD_NS - 1) / AXD_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        AXD_SPI_IDLE,
        AXD_SPI_INSTR,
        AXD_SPI_DATA,
        AXD_SPI_DONE
    } axd_spi_state_e;

endpackage

// file: rtl/axd_channel.sv
// one auxiliary converter channel: decode of its two registers onto the analog controls
`timescale 1ns/1ns
module axd_channel
    import axd_pkg::*;
#(
    parameter int          CODE_W      = AXD_CODE_W,
    parameter logic [2:0]  SHUNT_FLOOR = AXD_SHUNT_FLOOR
)
(
    input  wire logic              sys_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic [7:0]        code_reg_i,
    input  wire logic [7:0]        ctrl_reg_i,
    input  wire logic              internal_rset_i,
    output logic [CODE_W-1:0]      current_o,
    output logic                   pin_drive_o,
    output logic                   amp_enable_o,
    output logic                   amp_bypass_o,
    output logic [2:0]             shunt_sel_o,
    output logic [1:0]             range_o
);

    logic              enable;
    logic [2:0]        offset;
    logic [CODE_W-1:0] code;
    logic              usable;

    assign enable = ctrl_reg_i[AXD_CTRL_EN_BIT];
    assign offset = ctrl_reg_i[AXD_CTRL_OFS_HI:AXD_CTRL_OFS_LO];
    assign code   = {ctrl_reg_i[AXD_CTRL_CODE_HI:AXD_CTRL_CODE_LO], code_reg_i};
    assign usable = enable && internal_rset_i;

    // ------------------------------------------------------------------
    // analog control flops
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            current_o <= '0;
        end
        else
        begin
            // inverted decode: code zero is full scale
            current_o <= usable ? ~code : '0;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            pin_drive_o  <= 1'b0;
            amp_enable_o <= 1'b0;
            amp_bypass_o <= 1'b0;
        end
        else
        begin
            // disabled means open circuit: neither amplifier nor raw current
            pin_drive_o  <= usable;
            amp_enable_o <= usable && (offset != AXD_OFS_BYPASS);
            amp_bypass_o <= usable && (offset == AXD_OFS_BYPASS);
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            shunt_sel_o <= '0;
            range_o     <= '0;
        end
        else
        begin
            // clamp rather than wrap: an out-of-range offset still gives the lowest legal shunt
            shunt_sel_o <= (offset > SHUNT_FLOOR) ? SHUNT_FLOOR : offset;
            range_o     <= ctrl_reg_i[AXD_CTRL_RANGE_HI:AXD_CTRL_RANGE_LO];
        end
    end

endmodule

// file: rtl/axd_control.sv
// auxiliary converter control: serial register port, mode detection and two channels
`timescale 1ns/1ns
module axd_control
    import axd_pkg::*;
#(
    parameter int CODE_W     = AXD_CODE_W,
    parameter int PULSE_CYC  = AXD_MODE_PULSE_CYC
)
(
    input  wire logic              sys_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              reset_mode_pin_i,
    input  wire logic              spi_cs_n_i,
    input  wire logic              spi_sclk_i,
    input  wire logic              spi_sdio_i,
    output logic                   spi_sdio_o,
    output logic                   spi_sdio_oe_o,
    input  wire logic              inphase_internal_rset_i,
    input  wire logic              quad_internal_rset_i,
    output logic                   serial_mode_o,
    output logic [CODE_W-1:0]      inphase_aux_current_o,
    output logic                   inphase_fullscale_aux_pin_drive_o,
    output logic                   inphase_aux_amp_enable_o,
    output logic                   inphase_aux_amp_bypass_o,
    output logic [2:0]             inphase_aux_shunt_sel_o,
    output logic [1:0]             inphase_aux_range_o,
    output logic [CODE_W-1:0]      quad_aux_current_o,
    output logic                   quad_fullscale_aux_pin_drive_o,
    output logic                   quad_aux_amp_enable_o,
    output logic                   quad_aux_amp_bypass_o,
    output logic [2:0]             quad_aux_shunt_sel_o,
    output logic [1:0]             quad_aux_range_o
);

    // ------------------------------------------------------------------
    // reset and mode
    // ------------------------------------------------------------------
    localparam int PCNT_W = $clog2(PULSE_CYC + 1) + 1;

    logic [PCNT_W-1:0] pulse_cnt_q;
    logic              mode_pin_q;
    logic              serial_mode_q;
    logic              regs_clear;
    logic              pulse_long_enough;

    assign pulse_long_enough = (pulse_cnt_q >= PCNT_W'(PULSE_CYC));
    // registers held clear while the reset/mode pin is high
    assign regs_clear = !reset_n_i || reset_mode_pin_i;

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            pulse_cnt_q <= '0;
            mode_pin_q  <= 1'b0;
        end
        else
        begin
            mode_pin_q <= reset_mode_pin_i;
            if (!reset_mode_pin_i)
            begin
                pulse_cnt_q <= '0;
            end
            else if (!pulse_long_enough)
            begin
                pulse_cnt_q <= pulse_cnt_q + PCNT_W'(1);
            end
        end
    end

    // serial mode entered on the falling edge of a long enough high pulse
    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            serial_mode_q <= 1'b0;
        end
        else if (reset_mode_pin_i)
        begin
            serial_mode_q <= 1'b0;
        end
        else if (mode_pin_q && pulse_long_enough)
        begin
            serial_mode_q <= 1'b1;
        end
    end

    assign serial_mode_o = serial_mode_q;

    // ------------------------------------------------------------------
    // serial port engine
    // ------------------------------------------------------------------
    axd_spi_state_e state_q;
    logic           sclk_q;
    logic           sclk_rise;
    logic           sclk_fall;
    logic [3:0]     bit_cnt_q;
    logic [7:0]     shift_q;
    logic           read_q;
    logic [4:0]     addr_q;
    logic           wr_stb;
    logic [7:0]     wr_data;
    logic [7:0]     rd_data;
    logic [7:0]     rd_shift_q;
    logic           port_live;

    // pin mode leaves the port dead: no access to the registers at all
    assign port_live = serial_mode_q && !spi_cs_n_i;
    assign sclk_rise = spi_sclk_i && !sclk_q;
    assign sclk_fall = !spi_sclk_i && sclk_q;
    assign wr_data   = {shift_q[6:0], spi_sdio_i};
    // write takes effect only on the last data bit of the frame
    assign wr_stb    = (state_q == AXD_SPI_DATA) && port_live && sclk_rise && !read_q
                       && (bit_cnt_q == 4'(AXD_FRAME_BITS - 1));

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            sclk_q <= 1'b0;
        end
        else
        begin
            sclk_q <= spi_sclk_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (regs_clear)
        begin
            state_q   <= AXD_SPI_IDLE;
            bit_cnt_q <= '0;
            shift_q   <= '0;
            read_q    <= 1'b0;
            addr_q    <= '0;
        end
        else if (!port_live)
        begin
            // chip select high aborts any partial frame
            state_q   <= AXD_SPI_IDLE;
            bit_cnt_q <= '0;
        end
        else
        begin
            case (state_q)
                AXD_SPI_IDLE:
                begin
                    state_q   <= AXD_SPI_INSTR;
                    bit_cnt_q <= '0;
                end
                AXD_SPI_INSTR:
                begin
                    if (sclk_rise)
                    begin
                        shift_q   <= wr_data;
                        bit_cnt_q <= bit_cnt_q + 4'd1;
                        if (bit_cnt_q == 4'(AXD_INSTR_BITS - 1))
                        begin
                            read_q  <= shift_q[AXD_READ_BIT - 1];
                            addr_q  <= wr_data[4:0];
                            state_q <= AXD_SPI_DATA;
                        end
                    end
                end
                AXD_SPI_DATA:
                begin
                    if (sclk_rise)
                    begin
                        shift_q   <= wr_data;
                        bit_cnt_q <= bit_cnt_q + 4'd1;
                        if (bit_cnt_q == 4'(AXD_FRAME_BITS - 1))
                        begin
                            state_q <= AXD_SPI_DONE;
                        end
                    end
                end
                AXD_SPI_DONE:
                begin
                    state_q <= AXD_SPI_DONE;
                end
                default:
                begin
                    state_q <= AXD_SPI_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [7:0] i_code_q;
    logic [7:0] i_ctrl_q;
    logic [7:0] q_code_q;
    logic [7:0] q_ctrl_q;

    // each channel's pair written independently of the other
    always_ff @(posedge sys_clk_i)
    begin
        if (regs_clear)
        begin
            i_code_q <= AXD_CODE_RESET;
            i_ctrl_q <= AXD_CTRL_RESET;
        end
        else if (wr_stb)
        begin
            if (addr_q == AXD_ADDR_I_CODE)
            begin
                i_code_q <= wr_data;
            end
            if (addr_q == AXD_ADDR_I_CTRL)
            begin
                i_ctrl_q <= wr_data;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (regs_clear)
        begin
            q_code_q <= AXD_CODE_RESET;
            q_ctrl_q <= AXD_CTRL_RESET;
        end
        else if (wr_stb)
        begin
            if (addr_q == AXD_ADDR_Q_CODE)
            begin
                q_code_q <= wr_data;
            end
            if (addr_q == AXD_ADDR_Q_CTRL)
            begin
                q_ctrl_q <= wr_data;
            end
        end
    end

    always_comb
    begin
        case (addr_q)
            AXD_ADDR_I_CODE: rd_data = i_code_q;
            AXD_ADDR_I_CTRL: rd_data = i_ctrl_q;
            AXD_ADDR_Q_CODE: rd_data = q_code_q;
            AXD_ADDR_Q_CTRL: rd_data = q_ctrl_q;
            default:         rd_data = AXD_UNMAPPED;
        endcase
    end

    // ------------------------------------------------------------------
    // read back
    // ------------------------------------------------------------------
    // data changes on the falling clock so the host samples it on the rise
    always_ff @(posedge sys_clk_i)
    begin
        if (regs_clear)
        begin
            rd_shift_q    <= '0;
            spi_sdio_oe_o <= 1'b0;
            spi_sdio_o    <= 1'b0;
        end
        else if (!port_live || !read_q || state_q != AXD_SPI_DATA)
        begin
            spi_sdio_oe_o <= 1'b0;
            spi_sdio_o    <= 1'b0;
            if (state_q == AXD_SPI_INSTR && bit_cnt_q == 4'(AXD_INSTR_BITS))
            begin
                rd_shift_q <= '0;
            end
        end
        else if (sclk_fall)
        begin
            if (bit_cnt_q == 4'(AXD_INSTR_BITS))
            begin
                spi_sdio_oe_o <= 1'b1;
                spi_sdio_o    <= rd_data[7];
                rd_shift_q    <= {rd_data[6:0], 1'b0};
            end
            else
            begin
                spi_sdio_o <= rd_shift_q[7];
                rd_shift_q <= {rd_shift_q[6:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------------
    // channels
    // ------------------------------------------------------------------
    axd_channel #(
        .CODE_W      (CODE_W),
        .SHUNT_FLOOR (AXD_SHUNT_FLOOR)
    ) u_inphase (
        .sys_clk_i       (sys_clk_i),
        .reset_n_i       (reset_n_i),
        .code_reg_i      (i_code_q),
        .ctrl_reg_i      (i_ctrl_q),
        .internal_rset_i (inphase_internal_rset_i),
        .current_o       (inphase_aux_current_o),
        .pin_drive_o     (inphase_fullscale_aux_pin_drive_o),
        .amp_enable_o    (inphase_aux_amp_enable_o),
        .amp_bypass_o    (inphase_aux_amp_bypass_o),
        .shunt_sel_o     (inphase_aux_shunt_sel_o),
        .range_o         (inphase_aux_range_o)
    );

    axd_channel #(
        .CODE_W      (CODE_W),
        .SHUNT_FLOOR (AXD_SHUNT_FLOOR)
    ) u_quad (
        .sys_clk_i       (sys_clk_i),
        .reset_n_i       (reset_n_i),
        .code_reg_i      (q_code_q),
        .ctrl_reg_i      (q_ctrl_q),
        .internal_rset_i (quad_internal_rset_i),
        .current_o       (quad_aux_current_o),
        .pin_drive_o     (quad_fullscale_aux_pin_drive_o),
        .amp_enable_o    (quad_aux_amp_enable_o),
        .amp_bypass_o    (quad_aux_amp_bypass_o),
        .shunt_sel_o     (quad_aux_shunt_sel_o),
        .range_o         (quad_aux_range_o)
    );

endmodule

// file: test/axd_control_bench.sv
// self-checking bench for the auxiliary converter control block
`timescale 1ns/1ns
module axd_control_bench;
    import axd_pkg::*;

    logic       sys_clk, reset_n, i_rset, q_rset;
    logic       h_mode, h_cs_n, h_sclk, h_sdio, sdo, soe, smode;
    logic [9:0] i_cur, q_cur;
    logic       i_pin, i_amp, i_byp, q_pin, q_amp, q_byp;
    logic [2:0] i_sh, q_sh;
    logic [1:0] i_rg, q_rg;
    logic [7:0] rdv;
    int         fails, checks_done;
    wire        sdio_w = soe ? sdo : h_sdio;
    wire [17:0] i_vec  = {i_pin, i_amp, i_byp, i_sh, i_rg, i_cur};
    wire [17:0] q_vec  = {q_pin, q_amp, q_byp, q_sh, q_rg, q_cur};

    axd_control #(.PULSE_CYC(2)) u_dut (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .reset_mode_pin_i(h_mode), .spi_cs_n_i(h_cs_n),
        .spi_sclk_i(h_sclk), .spi_sdio_i(sdio_w), .spi_sdio_o(sdo), .spi_sdio_oe_o(soe),
        .inphase_internal_rset_i(i_rset), .quad_internal_rset_i(q_rset), .serial_mode_o(smode),
        .inphase_aux_current_o(i_cur), .inphase_fullscale_aux_pin_drive_o(i_pin),
        .inphase_aux_amp_enable_o(i_amp), .inphase_aux_amp_bypass_o(i_byp), .inphase_aux_shunt_sel_o(i_sh),
        .inphase_aux_range_o(i_rg), .quad_aux_current_o(q_cur), .quad_fullscale_aux_pin_drive_o(q_pin),
        .quad_aux_amp_enable_o(q_amp), .quad_aux_amp_bypass_o(q_byp), .quad_aux_shunt_sel_o(q_sh),
        .quad_aux_range_o(q_rg));

    axd_host u_host (.sys_clk_i(sys_clk), .sdio_i(sdio_w), .mode_pin_o(h_mode), .cs_n_o(h_cs_n),
                     .sclk_o(h_sclk), .sdio_o(h_sdio));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [17:0] exp_ch(input logic [7:0] ctrl, input logic [7:0] code, input logic rset);
        logic       on;
        logic [2:0] ofs;
        on  = ctrl[7] & rset;
        ofs = ctrl[4:2];
        return {on, on & (ofs != 3'h7), on & (ofs == 3'h7), (ofs > 3'h4) ? 3'h4 : ofs, ctrl[6:5],
                on ? ~{ctrl[1:0], code} : 10'h000};
    endfunction

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_ch(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        u_host.frame({3'h0, addr}, data, 16, rdv);
    endtask

    task automatic rd(input logic [4:0] addr);
        u_host.frame({3'h4, addr}, 8'h00, 16, rdv);
    endtask

    task automatic complete_run();
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        #200000;
        fails++;
        complete_run();
    end

    initial
    begin
        fails   = 0;
        checks_done = 0;
        reset_n = 1'b0;
        i_rset  = 1'b1;
        q_rset  = 1'b1;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        chk_ch(i_vec, 18'h0_0000);
        chk_reg({7'h00, smode}, 8'h00);
        u_host.mode_pulse(1);
        chk_reg({7'h00, smode}, 8'h00);
        wr(AXD_ADDR_I_CTRL, 8'h80);
        chk_ch(i_vec, 18'h0_0000);
        u_host.mode_pulse(2);
        chk_reg({7'h00, smode}, 8'h01);
        wr(AXD_ADDR_I_CODE, 8'h00);
        wr(AXD_ADDR_I_CTRL, 8'h80);
        chk_ch(i_vec, exp_ch(8'h80, 8'h00, 1'b1));
        chk_ch(q_vec, 18'h0_0000);
        wr(AXD_ADDR_I_CODE, 8'hff);
        wr(AXD_ADDR_I_CTRL, 8'h83);
        chk_ch(i_vec, exp_ch(8'h83, 8'hff, 1'b1));
        for (int k = 0; k < 8; k++)
        begin
            wr(AXD_ADDR_I_CTRL, 8'h80 | 8'(k % 4) << 5 | 8'(k) << 2 | 8'h01);
            chk_ch(i_vec, exp_ch(8'h80 | 8'(k % 4) << 5 | 8'(k) << 2 | 8'h01, 8'hff, 1'b1));
        end
        i_rset = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk_ch(i_vec, exp_ch(8'hfd, 8'hff, 1'b0));
        i_rset = 1'b1;
        wr(AXD_ADDR_I_CTRL, 8'h1c);
        chk_ch(i_vec, exp_ch(8'h1c, 8'hff, 1'b1));
        wr(AXD_ADDR_Q_CODE, 8'h5a);
        wr(AXD_ADDR_Q_CTRL, 8'ha6);
        chk_ch(q_vec, exp_ch(8'ha6, 8'h5a, 1'b1));
        q_rset = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk_ch(q_vec, exp_ch(8'ha6, 8'h5a, 1'b0));
        q_rset = 1'b1;
        rd(AXD_ADDR_I_CTRL);
        chk_reg(rdv, 8'h1c);
        rd(AXD_ADDR_Q_CTRL);
        chk_reg(rdv, 8'ha6);
        rd(AXD_ADDR_I_CODE);
        chk_reg(rdv, 8'hff);
        rd(5'h1f);
        chk_reg(rdv, AXD_UNMAPPED);
        u_host.frame({3'h0, AXD_ADDR_Q_CTRL}, 8'h00, 10, rdv);
        chk_ch(q_vec, exp_ch(8'ha6, 8'h5a, 1'b1));
        rd(AXD_ADDR_Q_CTRL);
        chk_reg(rdv, 8'ha6);
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        chk_ch(q_vec, 18'h0_0000);
        chk_ch(i_vec, 18'h0_0000);
        complete_run();
    end
endmodule

// file: test/axd_control_sva.sv
// concurrent checks on the auxiliary converter control ports
`timescale 1ns/1ns
module axd_control_sva
    import axd_pkg::*;
#(
    parameter int CODE_W    = AXD_CODE_W,
    parameter int PULSE_CYC = AXD_MODE_PULSE_CYC
)
(
    input wire logic              sys_clk_i,
    input wire logic              reset_n_i,
    input wire logic              reset_mode_pin_i,
    input wire logic              spi_cs_n_i,
    input wire logic              spi_sclk_i,
    input wire logic              spi_sdio_i,
    input wire logic              spi_sdio_o,
    input wire logic              spi_sdio_oe_o,
    input wire logic              inphase_internal_rset_i,
    input wire logic              quad_internal_rset_i,
    input wire logic              serial_mode_o,
    input wire logic [CODE_W-1:0] inphase_aux_current_o,
    input wire logic              inphase_fullscale_aux_pin_drive_o,
    input wire logic              inphase_aux_amp_enable_o,
    input wire logic              inphase_aux_amp_bypass_o,
    input wire logic [2:0]        inphase_aux_shunt_sel_o,
    input wire logic [1:0]        inphase_aux_range_o,
    input wire logic [CODE_W-1:0] quad_aux_current_o,
    input wire logic              quad_fullscale_aux_pin_drive_o,
    input wire logic              quad_aux_amp_enable_o,
    input wire logic              quad_aux_amp_bypass_o,
    input wire logic [2:0]        quad_aux_shunt_sel_o,
    input wire logic [1:0]        quad_aux_range_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    // first edge has no history, so the reset check waits one edge
    logic started_q;
    always_ff @(posedge sys_clk_i)
        started_q <= 1'b1;

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    a_reset_clears_all: assert property (disable iff (1'b0) started_q && $past(!reset_n_i) |->
        !inphase_fullscale_aux_pin_drive_o && !quad_fullscale_aux_pin_drive_o && !serial_mode_o
        && inphase_aux_current_o == '0 && quad_aux_current_o == '0 && !spi_sdio_oe_o)
        else $error("outputs not cleared by reset");
    a_pin_needs_rset: assert property (inphase_fullscale_aux_pin_drive_o |-> $past(inphase_internal_rset_i))
        else $error("aux pin driven without internal resistor");
    a_quad_needs_rset: assert property (quad_fullscale_aux_pin_drive_o |-> $past(quad_internal_rset_i))
        else $error("quad aux pin driven without internal resistor");
    a_off_is_open: assert property (!quad_fullscale_aux_pin_drive_o |-> quad_aux_current_o == '0
        && !quad_aux_amp_enable_o && !quad_aux_amp_bypass_o)
        else $error("disabled aux output not open");
    a_amp_or_bypass: assert property (inphase_fullscale_aux_pin_drive_o |->
        inphase_aux_amp_enable_o != inphase_aux_amp_bypass_o)
        else $error("amplifier and bypass disagree");
    a_bypass_at_floor: assert property (inphase_aux_amp_bypass_o |->
        inphase_aux_shunt_sel_o == AXD_SHUNT_FLOOR && inphase_fullscale_aux_pin_drive_o)
        else $error("bypass without all-ones offset");
    a_shunt_floor_kept: assert property (inphase_aux_shunt_sel_o <= AXD_SHUNT_FLOOR
        && quad_aux_shunt_sel_o <= AXD_SHUNT_FLOOR)
        else $error("shunt below floor selected");
    a_mode_pin_exit: assert property (reset_mode_pin_i |=> !serial_mode_o)
        else $error("serial mode while mode pin high");
    a_idle_no_drive: assert property ($past(spi_cs_n_i) && $past(spi_cs_n_i, 2) |-> !spi_sdio_oe_o)
        else $error("data line driven outside a frame");
    a_write_holds: assert property (spi_cs_n_i && $past(spi_cs_n_i) && $past(spi_cs_n_i, 2)
        && $past(inphase_internal_rset_i) == $past(inphase_internal_rset_i, 2)
        && !$past(reset_mode_pin_i) && !$past(reset_mode_pin_i, 2) && $past(reset_n_i)
        |-> $stable(inphase_aux_current_o))
        else $error("aux code changed without a write");

    c_bypass: cover property (inphase_aux_amp_bypass_o);
    c_read_drive: cover property (spi_sdio_oe_o);
    c_mode_entry: cover property ($rose(serial_mode_o));
endmodule

bind axd_control axd_control_sva #(.CODE_W(CODE_W), .PULSE_CYC(PULSE_CYC)) u_sva (
    .sys_clk_i, .reset_n_i, .reset_mode_pin_i, .spi_cs_n_i, .spi_sclk_i, .spi_sdio_i, .spi_sdio_o,
    .spi_sdio_oe_o, .inphase_internal_rset_i, .quad_internal_rset_i, .serial_mode_o,
    .inphase_aux_current_o, .inphase_fullscale_aux_pin_drive_o, .inphase_aux_amp_enable_o,
    .inphase_aux_amp_bypass_o, .inphase_aux_shunt_sel_o, .inphase_aux_range_o, .quad_aux_current_o,
    .quad_fullscale_aux_pin_drive_o, .quad_aux_amp_enable_o, .quad_aux_amp_bypass_o,
    .quad_aux_shunt_sel_o, .quad_aux_range_o);

// file: test/axd_host.sv
// serial control host model driving the mode pin and register frames
`timescale 1ns/1ns
module axd_host
(
    input  wire logic sys_clk_i,
    input  wire logic sdio_i,
    output logic      mode_pin_o,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      sdio_o
);
    initial
    begin
        mode_pin_o = 1'b0;
        cs_n_o     = 1'b1;
        sclk_o     = 1'b0;
        sdio_o     = 1'b0;
    end

    task automatic mode_pulse(input int cyc);
        @(negedge sys_clk_i);
        mode_pin_o = 1'b1;
        repeat (cyc) @(negedge sys_clk_i);
        mode_pin_o = 1'b0;
        repeat (3) @(negedge sys_clk_i);
    endtask

    // each frame carries nbits bits, fewer than 16 for a partial frame, chip select high between frames
    task automatic frame(input logic [7:0] instr, input logic [7:0] wdata, input int nbits,
                         output logic [7:0] rdata);
        logic [15:0] word;
        word  = {instr, wdata};
        rdata = 8'h00;
        @(negedge sys_clk_i);
        cs_n_o = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            // released line toggles so a stale level never passes for data
            sdio_o = (i > 7 && instr[7]) ? ~sdio_o : word[15-i];
            repeat (3) @(negedge sys_clk_i);
            if (i > 7)
                rdata[15-i] = sdio_i;
            sclk_o = 1'b1;
            repeat (2) @(negedge sys_clk_i);
            sclk_o = 1'b0;
        end
        @(negedge sys_clk_i);
        cs_n_o = 1'b1;
        sdio_o = ~sdio_o;
        repeat (3) @(negedge sys_clk_i);
    endtask
endmodule
